// File: pdc_cfg_top.sv
// divider and charge pump configuration registers behind the serial port
`default_nettype none

module pdc_cfg_top
	import pdc_pkg::*;
(
	input  wire logic                 mclk,
	input  wire logic                 reset,
	input  wire logic                 sck,
	input  wire logic                 csb_n,
	input  wire logic                 sdi,
	output logic                      sdo,
	output logic                      sdo_en,
	output logic [POST_DIV_W-1:0]     post_div_ratio,
	output logic [PRE_DIV_W-1:0]      pre_div_ratio,
	output logic                      pump_enable,
	output logic [MODE_W-1:0]         detector_mode_select,
	output logic [CURRENT_W-1:0]      pump_sink_current,
	output logic [CURRENT_W-1:0]      pump_source_current
);

	// ************************************************************
	// serial port
	// ************************************************************
	pdc_frame_if fr ();   // frame strobes and readback

	pdc_serial_port u_port (
		.mclk   (mclk),
		.reset  (reset),
		.sck    (sck),
		.csb_n  (csb_n),
		.sdi    (sdi),
		.sdo    (sdo),
		.sdo_en (sdo_en),
		.fr     (fr)
	);

	// ************************************************************
	// register file
	// ************************************************************
	localparam logic [REG_COUNT-1:0][DATA_W-1:0] RESET_WORDS = {
		RESET_CURRENT_WORD, RESET_CTRL_WORD,
		RESET_PRE_WORD, RESET_POST_WORD};

	logic [REG_COUNT-1:0][DATA_W-1:0] word_reg, word_next; // words
	logic [REG_COUNT-1:0]             hit;                 // addr match

	// one decoder per register
	genvar gi;
	generate
		for (gi = 0; gi < REG_COUNT; gi++)
		begin : g_dec
			assign hit[gi] = (fr.addr ==
				ADDR_W'(ADDR_REF_POST_DIVIDER + gi));
		end
	endgenerate

	// write decode; whole word stored, unmapped writes dropped
	always_comb
	begin
		word_next = word_reg;
		for (int i = 0; i < REG_COUNT; i++)
		begin
			if (fr.wr_valid && hit[i])
			begin
				word_next[i] = fr.wdata;
			end
		end
	end

	// readback mux; unmapped addresses read zero
	always_comb
	begin
		fr.rd_data = '0;
		for (int i = 0; i < REG_COUNT; i++)
		begin
			if (hit[i])
			begin
				fr.rd_data = word_reg[i];
			end
		end
	end

	// register storage, defaults on reset
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			word_reg <= RESET_WORDS;
		end
		else
		begin
			word_reg <= word_next;
		end
	end

	// ************************************************************
	// field outputs
	// ************************************************************
	assign post_div_ratio = word_reg[0][POST_DIV_LSB +: POST_DIV_W];
	assign pre_div_ratio  = word_reg[1][PRE_DIV_LSB +: PRE_DIV_W];
	assign pump_enable    = word_reg[2][PUMP_EN_BIT];
	assign detector_mode_select = word_reg[2][MODE_LSB +: MODE_W];
	assign pump_sink_current   = word_reg[3][SINK_LSB +: CURRENT_W];
	assign pump_source_current = word_reg[3][SOURCE_LSB +: CURRENT_W];

	// ************************************************************
	// assertions
	// ************************************************************
	sequence s_write(logic [ADDR_W-1:0] a);
		fr.wr_valid && (fr.addr == a);
	endsequence

	AST_POST_DIV: assert property (@(posedge mclk) disable iff (reset)
		s_write(ADDR_REF_POST_DIVIDER) |=>
		post_div_ratio == $past(fr.wdata[POST_DIV_LSB +: POST_DIV_W]))
		else $error("post divider ratio not taken from write");

	AST_PRE_DIV: assert property (@(posedge mclk) disable iff (reset)
		s_write(ADDR_REF_PRE_DIVIDER) |=>
		pre_div_ratio == $past(fr.wdata[PRE_DIV_LSB +: PRE_DIV_W]))
		else $error("pre divider ratio not taken from write");

	AST_PUMP_EN: assert property (@(posedge mclk) disable iff (reset)
		s_write(ADDR_PUMP_AND_DETECTOR_CONTROL) |=>
		pump_enable == $past(fr.wdata[PUMP_EN_BIT]))
		else $error("pump enable not taken from bit 14");

	AST_MODE: assert property (@(posedge mclk) disable iff (reset)
		s_write(ADDR_PUMP_AND_DETECTOR_CONTROL) |=>
		detector_mode_select == $past(fr.wdata[MODE_LSB +: MODE_W]))
		else $error("detector mode not taken from bits 9:8");

	AST_SINK: assert property (@(posedge mclk) disable iff (reset)
		s_write(ADDR_PUMP_CURRENT_SETTING) |=>
		pump_sink_current == $past(fr.wdata[SINK_LSB +: CURRENT_W]))
		else $error("sink current not taken from bits 11:7");

	AST_SOURCE: assert property (@(posedge mclk) disable iff (reset)
		s_write(ADDR_PUMP_CURRENT_SETTING) |=>
		pump_source_current == $past(fr.wdata[SOURCE_LSB +: CURRENT_W]))
		else $error("source current not taken from bits 6:2");

	AST_RESET_DEFAULTS: assert property (@(posedge mclk)
		$past(reset) |-> (post_div_ratio == POST_DIV_DEFAULT) &&
		(pre_div_ratio == PRE_DIV_DEFAULT) &&
		(pump_enable == PUMP_EN_DEFAULT) &&
		(detector_mode_select == MODE_DUAL) &&
		(pump_sink_current == CURRENT_DEFAULT) &&
		(pump_source_current == CURRENT_DEFAULT))
		else $error("fields not at defaults after reset");

	AST_HOLD: assert property (@(posedge mclk) disable iff (reset)
		!fr.wr_valid ##1 !fr.wr_valid |-> $stable(word_reg))
		else $error("register changed without a write");

	// ************************************************************
	// assertions: decode isolation and strobe shape
	// ************************************************************
	// a full frame to an address outside the bank
	sequence s_stray_write;
		fr.wr_valid && (hit == '0);
	endsequence

	// strobe high on two edges in a row
	sequence s_double_strobe;
		fr.wr_valid ##1 fr.wr_valid;
	endsequence

	// writes outside the bank are dropped, nothing moves
	AST_STRAY: assert property (@(posedge mclk) disable iff (reset)
		s_stray_write |=> $stable(word_reg))
		else $error("write outside the bank changed a register");

	// a stray address reads back as zero
	AST_STRAY_READ: assert property (@(posedge mclk)
		disable iff (reset)
		(hit == '0) |-> (fr.rd_data == '0))
		else $error("unmapped address read back nonzero");

	// one commit per frame; a stuck strobe would rewrite each cycle
	AST_ONE_STROBE: assert property (@(posedge mclk)
		disable iff (reset)
		not s_double_strobe)
		else $error("write strobe stood for two cycles");

	// per word: it only moves after a write that hits it, and
	// readback at its address shows the stored word
	genvar gc;
	generate
		for (gc = 0; gc < REG_COUNT; gc++)
		begin : g_word_chk
			AST_CAUSE: assert property (@(posedge mclk)
				disable iff (reset)
				!$stable(word_reg[gc]) |->
				$past(fr.wr_valid && hit[gc]))
				else $error("word moved without its own write");

			AST_READBACK: assert property (@(posedge mclk)
				disable iff (reset)
				hit[gc] |-> (fr.rd_data == word_reg[gc]))
				else $error("readback differs from stored word");
		end
	endgenerate

endmodule // pdc_cfg_top

`default_nettype wire

// File: pdc_cfg_top_bench.sv
// self-checking bench for the divider and charge pump registers
`default_nettype none

module pdc_cfg_top_bench;
	timeunit 1ns;
	timeprecision 1ps;

	// ************************************************************
	// signals and instances
	// ************************************************************
	logic        mclk = 1'b0;
	logic        reset = 1'b1;
	logic        sck, csb_n, sdi, sdo, sdo_en;
	logic [7:0]  post_div_ratio;
	logic [11:0] pre_div_ratio;
	logic        pump_enable;
	logic [1:0]  detector_mode_select;
	logic [4:0]  pump_sink_current, pump_source_current;
	logic [15:0] model_word [4];       // expected register words
	logic [31:0] seed = 32'h00014034;  // xorshift state
	logic [15:0] q;
	logic        en;
	int          fail_count = 0;
	int          checked = 0;
	int          cycles = 0;

	always #2.5 mclk = ~mclk;

	pdc_cfg_top pdc_cfg_top_i (.mclk(mclk), .reset(reset), .sck(sck),
		.csb_n(csb_n), .sdi(sdi), .sdo(sdo), .sdo_en(sdo_en),
		.post_div_ratio(post_div_ratio), .pre_div_ratio(pre_div_ratio),
		.pump_enable(pump_enable),
		.detector_mode_select(detector_mode_select),
		.pump_sink_current(pump_sink_current),
		.pump_source_current(pump_source_current));

	pdc_host_model pdc_host_model_i (.mclk(mclk), .sdo(sdo),
		.sdo_en(sdo_en), .sck(sck), .csb_n(csb_n), .sdi(sdi));

	// ************************************************************
	// helpers
	// ************************************************************
	function automatic logic [31:0] xorshift();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		checked++;
		if (seen !== want)
		begin
			fail_count++;
			$display("[FAIL] %0t ns seen %h want %h", $time, seen, want);
		end
	endtask

	// defaults after reset, unnamed bits zero
	task automatic model_reset();
		model_word[0] = 16'h0010;
		model_word[1] = 16'h0001;
		model_word[2] = 16'h4000;
		model_word[3] = 16'h018C;
	endtask

	task automatic check_outputs();
		check(16'(post_div_ratio), 16'(model_word[0][11:4]));
		check(16'(pre_div_ratio), 16'(model_word[1][11:0]));
		check(16'(pump_enable), 16'(model_word[2][14]));
		check(16'(detector_mode_select), 16'(model_word[2][9:8]));
		check(16'(pump_sink_current), 16'(model_word[3][11:7]));
		check(16'(pump_source_current), 16'(model_word[3][6:2]));
	endtask

	task automatic read_check(input int idx);
		pdc_host_model_i.frame({1'b1, 7'h0B + 7'(idx), 16'h0000}, 24, q, en);
		check(q, model_word[idx]);
		check(16'(en), 16'h0001);
		// readback driver must be off once the host deselects
		check(16'(sdo_en), 16'h0000);
	endtask

	task automatic write_check(input int idx, input logic [15:0] d);
		pdc_host_model_i.frame({1'b0, 7'h0B + 7'(idx), d}, 24, q, en);
		model_word[idx] = d;
		check_outputs();
		read_check(idx);
	endtask

	task automatic final_report();
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// hang guard: about 45 frames of 210 cycles expected
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			fail_count++;
			final_report();
		end
	end

	// ************************************************************
	// main sequence
	// ************************************************************
	initial
	begin
		int          idx;
		logic [31:0] r;
		logic [15:0] d;
		int          pfd_mhz;
		repeat (4) @(posedge mclk);
		reset <= 1'b0;
		repeat (4) @(posedge mclk);
		model_reset();
		check_outputs();
		for (int i = 0; i < 4; i++)
			read_check(i);
		// random writes; other words must hold
		for (int n = 0; n < 16; n++)
		begin
			r = xorshift();
			idx = int'(r[31:30]);
			pfd_mhz = r[1] ? 250 : 100;
			case (idx)
				0: d = {4'h0, r[7:0], 4'h0};
				1: d = {4'h0, r[11:0]};
				// single detector only above 200 MHz
				2: d = {1'b0, r[0], 4'h0,
					(pfd_mhz > 200) ? 2'h3 : 2'h0, 8'h00};
				default: d = {4'h0, r[6:2], r[6:2], 2'h0};
			endcase
			write_check(idx, d);
		end
		// single detector at a 250 MHz comparison rate, then pump off
		write_check(2, 16'h4300);
		write_check(2, 16'h0000);
		// unmapped address: write ignored, read gives zero
		pdc_host_model_i.frame({1'b0, 7'h0F, 16'hFFFF}, 24, q, en);
		check_outputs();
		pdc_host_model_i.frame({1'b1, 7'h0F, 16'h0000}, 24, q, en);
		check(q, 16'h0000);
		// aborted write of inverted data leaves the word alone
		pdc_host_model_i.frame({1'b0, 7'h0D, ~model_word[2]}, 20, q, en);
		check_outputs();
		read_check(2);
		// reset in mid-run restores defaults
		reset <= 1'b1;
		repeat (4) @(posedge mclk);
		reset <= 1'b0;
		repeat (4) @(posedge mclk);
		model_reset();
		check_outputs();
		read_check(3);
		final_report();
	end
endmodule // pdc_cfg_top_bench

`default_nettype wire

// File: pdc_frame_if.sv
// carrier between the serial port and the register file
`default_nettype none

interface pdc_frame_if;
	import pdc_pkg::*;

	logic              wr_valid;   // one-cycle write strobe
	logic [ADDR_W-1:0] addr;       // register address of the frame
	logic [DATA_W-1:0] wdata;      // data to write
	logic [DATA_W-1:0] rd_data;    // word at addr, for readback

	modport port (output wr_valid, output addr, output wdata,
		input rd_data);
	modport regs (input wr_valid, input addr, input wdata,
		output rd_data);
endinterface : pdc_frame_if

`default_nettype wire

// File: pdc_host_model.sv
// host controller model that drives the serial programming pins
`default_nettype none

module pdc_host_model
(
	input  wire logic mclk,
	input  wire logic sdo,
	input  wire logic sdo_en,
	output logic      sck,
	output logic      csb_n,
	output logic      sdi
);
	timeunit 1ns;
	timeprecision 1ps;

	// idle pins: serial clock stands low, select off
	initial
	begin
		sck = 1'b0;
		csb_n = 1'b1;
		sdi = 1'b0;
	end

	// wait n rising edges of mclk
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask

	// one frame, msb first, each sck level 4 mclk; q gathers readback
	task automatic frame(input logic [23:0] w, input int nbits,
		output logic [15:0] q, output logic en);
		q = 16'h0000;
		en = 1'b1;
		@(posedge mclk);
		csb_n <= 1'b0;
		tick(4);
		for (int i = 0; i < nbits; i++)
		begin
			sdi <= w[23-i];
			tick(4);
			// readback bits settled since the last rise
			if (i >= 8)
			begin
				q = {q[14:0], sdo};
				en = en & sdo_en;
			end
			sck <= 1'b1;
			tick(4);
			sck <= 1'b0;
		end
		tick(4);
		csb_n <= 1'b1;
		// released data line must not keep its last value
		sdi <= ~sdi;
		tick(4);
	endtask
endmodule // pdc_host_model

`default_nettype wire

// File: pdc_pkg.sv
// shared constants for the synthesizer divider and charge pump registers
`default_nettype none

package pdc_pkg;

	// ************************************************************
	// serial frame layout
	// ************************************************************
	localparam int ADDR_W     = 7;         // register address bits
	localparam int DATA_W     = 16;        // register data bits
	localparam int HEAD_BITS  = 8;         // direction bit plus address
	localparam int FRAME_BITS = 24;        // whole frame length
	localparam int COUNT_W    = 5;         // bit counter width
	localparam int REG_COUNT  = 4;         // registers held here

	// ************************************************************
	// register addresses
	// ************************************************************
	localparam logic [6:0] ADDR_REF_POST_DIVIDER = 7'h0B;
	localparam logic [6:0] ADDR_REF_PRE_DIVIDER  = 7'h0C;
	localparam logic [6:0] ADDR_PUMP_AND_DETECTOR_CONTROL = 7'h0D;
	localparam logic [6:0] ADDR_PUMP_CURRENT_SETTING      = 7'h0E;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int POST_DIV_LSB = 4;       // post divider ratio 11:4
	localparam int POST_DIV_W   = 8;
	localparam int PRE_DIV_LSB  = 0;       // pre divider ratio 11:0
	localparam int PRE_DIV_W    = 12;
	localparam int PUMP_EN_BIT  = 14;      // charge pump enable
	localparam int MODE_LSB     = 8;       // detector mode 9:8
	localparam int MODE_W       = 2;
	localparam int SINK_LSB     = 7;       // sink current 11:7
	localparam int SOURCE_LSB   = 2;       // source current 6:2
	localparam int CURRENT_W    = 5;

	// ************************************************************
	// field defaults and detector mode codes
	// ************************************************************
	localparam logic [7:0]  POST_DIV_DEFAULT = 8'h01;
	localparam logic [11:0] PRE_DIV_DEFAULT  = 12'h001;
	localparam logic        PUMP_EN_DEFAULT  = 1'b1;
	localparam logic [1:0]  MODE_DUAL        = 2'h0;
	localparam logic [1:0]  MODE_SINGLE      = 2'h3;
	localparam logic [4:0]  CURRENT_DEFAULT  = 5'h03;

	// ************************************************************
	// whole-word reset values, unnamed bits zero
	// ************************************************************
	localparam logic [15:0] RESET_POST_WORD =
		16'(POST_DIV_DEFAULT) << POST_DIV_LSB;
	localparam logic [15:0] RESET_PRE_WORD =
		16'(PRE_DIV_DEFAULT) << PRE_DIV_LSB;
	localparam logic [15:0] RESET_CTRL_WORD =
		(16'(PUMP_EN_DEFAULT) << PUMP_EN_BIT) |
		(16'(MODE_DUAL) << MODE_LSB);
	localparam logic [15:0] RESET_CURRENT_WORD =
		(16'(CURRENT_DEFAULT) << SINK_LSB) |
		(16'(CURRENT_DEFAULT) << SOURCE_LSB);

endpackage : pdc_pkg

`default_nettype wire

// File: pdc_serial_port.sv
// serial programming port: pin synchroniser and frame shifter
`default_nettype none

module pdc_serial_port
	import pdc_pkg::*;
(
	input  wire logic mclk,
	input  wire logic reset,
	input  wire logic sck,
	input  wire logic csb_n,
	input  wire logic sdi,
	output logic      sdo,
	output logic      sdo_en,
	pdc_frame_if.port fr
);

	typedef enum logic [1:0] {
		PH_IDLE = 2'b00,   // chip select high
		PH_HEAD = 2'b01,   // direction and address
		PH_BODY = 2'b10,   // data bits
		PH_DONE = 2'b11    // extra clocks ignored
	} pdc_phase_type;

	// ************************************************************
	// pin synchronisers
	// ************************************************************
	logic [2:0] meta_reg;             // first stage: sck, csb_n, sdi
	logic [2:0] sync_reg;             // second stage
	logic       sck_last_reg;         // previous synced clock

	// two flops on every pin, first stage read only by second
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			meta_reg     <= 3'h2;
			sync_reg     <= 3'h2;
			sck_last_reg <= 1'b0;
		end
		else
		begin
			meta_reg     <= {sck, csb_n, sdi};
			sync_reg     <= meta_reg;
			sck_last_reg <= sync_reg[2];
		end
	end

	// ************************************************************
	// frame shifter
	// ************************************************************
	pdc_phase_type        phase_reg, phase_next;  // frame phase
	logic [COUNT_W-1:0]   count_reg, count_next;  // bits received
	logic [FRAME_BITS-1:0] in_reg, in_next;       // incoming bits
	logic [DATA_W-1:0]    out_reg, out_next;      // readback shifter
	logic                 rw_reg, rw_next;        // 1 = read frame
	logic                 rise;                   // sck rising edge
	logic                 sel;                    // chip selected
	logic [FRAME_BITS-1:0] shifted;               // in_reg plus sdi

	assign rise    = sync_reg[2] & ~sck_last_reg;
	assign sel     = ~sync_reg[1];
	assign shifted = {in_reg[FRAME_BITS-2:0], sync_reg[0]};

	// address is taken from the head while it ends, else the frame
	assign fr.addr  = (phase_reg == PH_HEAD) ? shifted[ADDR_W-1:0]
		: shifted[FRAME_BITS-2 -: ADDR_W];
	assign fr.wdata = shifted[DATA_W-1:0];
	// write fires on the last bit of a full write frame
	assign fr.wr_valid = sel && rise && (phase_reg == PH_BODY) && !rw_reg
		&& (count_reg == COUNT_W'(FRAME_BITS-1));

	assign sdo    = out_reg[DATA_W-1];
	assign sdo_en = sel && rw_reg && (phase_reg == PH_BODY);

	// next-state logic of the shifter
	always_comb
	begin
		phase_next = phase_reg;
		count_next = count_reg;
		in_next    = in_reg;
		out_next   = out_reg;
		rw_next    = rw_reg;
		if (!sel)
		begin
			// deselect aborts any partial frame
			phase_next = PH_IDLE;
			count_next = '0;
			rw_next    = 1'b0;
		end
		else
		begin
			unique case (phase_reg)
				PH_IDLE:
				begin
					phase_next = PH_HEAD;
				end
				PH_HEAD:
				begin
					if (rise)
					begin
						in_next    = shifted;
						count_next = count_reg + 1'b1;
						if (count_reg == COUNT_W'(HEAD_BITS-1))
						begin
							// head complete: load readback word
							rw_next    = shifted[HEAD_BITS-1];
							out_next   = fr.rd_data;
							phase_next = PH_BODY;
						end
					end
				end
				PH_BODY:
				begin
					if (rise)
					begin
						in_next    = shifted;
						count_next = count_reg + 1'b1;
						out_next   = {out_reg[DATA_W-2:0], 1'b0};
						if (count_reg == COUNT_W'(FRAME_BITS-1))
						begin
							phase_next = PH_DONE;
						end
					end
				end
				PH_DONE:
				begin
					phase_next = PH_DONE;
				end
			endcase
		end
	end

	// shifter registers
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			phase_reg <= PH_IDLE;
			count_reg <= '0;
			in_reg    <= '0;
			out_reg   <= '0;
			rw_reg    <= 1'b0;
		end
		else
		begin
			phase_reg <= phase_next;
			count_reg <= count_next;
			in_reg    <= in_next;
			out_reg   <= out_next;
			rw_reg    <= rw_next;
		end
	end

endmodule // pdc_serial_port

`default_nettype wire
